// >>> flow_ctrl_pkg.sv
// Constants, field layouts and types for the batch and flow control block
// How it works
// - Slow pulses 40 ms wide, 0-10 Hz
// - Fast output square wave, 0-1000 Hz
// - Batch start input begins a batch
// - Start clears batch counter, valve on
// - Counter counts; equal to setpoint turns valve off
// - Batch selection disables the flow regulator
// - Config words writable only with program enable
// - Setpoint restored at power-up from stored copy
// - Regulator output spans 4 to 20 mA
// - Output readable; written directly in manual mode
// - Proportional band: flow change for full swing
// - Integral time matches proportional step change
// - Digit A picks valve sense polarity
// - Digit B picks always-auto or input manual
// - Band, time, setpoint saved only when enabled
package flow_ctrl_pkg;
	localparam int CLK_HZ        = 20_000_000;
	localparam int SLOW_WIDTH_MS = 40;
	localparam int SLOW_WIDTH_CYC = (SLOW_WIDTH_MS * CLK_HZ + 999) / 1000;
	localparam int SLOW_CNT_W    = 20;
	localparam int SLOW_MAX_HZ   = 10;
	localparam int FAST_MAX_HZ   = 1000;
	// Fast output toggles twice per period
	localparam logic [31:0] SLOW_INC_MAX =
		32'((64'(SLOW_MAX_HZ) << 32) / 64'(CLK_HZ));
	localparam logic [31:0] FAST_INC_MAX =
		32'((64'(2 * FAST_MAX_HZ) << 32) / 64'(CLK_HZ));
	localparam int PI_SAMPLE_MS  = 100;
	localparam int PI_SAMPLE_CYC = PI_SAMPLE_MS * (CLK_HZ / 1000);
	localparam int PI_CNT_W      = 21;
	localparam int SAMPLES_PER_S = 1000 / PI_SAMPLE_MS;
	// Output position in hundredths of a percent
	localparam logic [15:0] OUT_FULL    = 16'h2710;
	localparam logic [15:0] CUR_MIN_UA  = 16'h0fa0;
	localparam logic [15:0] CUR_SPAN_UA = 16'h3e80;
	localparam logic [7:0] OFS_REG_CFG    = 8'h00;
	localparam logic [7:0] OFS_FUNC_SEL   = 8'h04;
	localparam logic [7:0] OFS_FLOW_OPT   = 8'h08;
	localparam logic [7:0] OFS_PBAND      = 8'h0c;
	localparam logic [7:0] OFS_ITIME      = 8'h10;
	localparam logic [7:0] OFS_SETPOINT   = 8'h14;
	localparam logic [7:0] OFS_OUT_PCT    = 8'h18;
	localparam logic [7:0] OFS_BATCH_VOL  = 8'h1c;
	localparam logic [7:0] OFS_STATUS     = 8'h20;
	localparam logic [7:0] OFS_SLOW_SCALE = 8'h24;
	localparam logic [7:0] OFS_FAST_SCALE = 8'h28;
	localparam logic [23:0] WORD_RST      = 24'h000000;
	localparam logic [15:0] VAL_RST       = 16'h0000;
	localparam logic [15:0] BATCH_FUNC_LO = 16'h2106;
	localparam logic [7:0]  PI_FUNC_HI    = 8'h18;
	localparam logic [3:0]  BATCH_OPT_D4  = 4'h4;
	localparam logic [3:0]  DIGIT_ZERO    = 4'h0;
	localparam logic [3:0]  SENSE_OPEN    = 4'h2;
	localparam logic [3:0]  MODE_INPUT    = 4'h2;
	typedef struct packed {
		logic [23:0] reg_cfg;
		logic [23:0] func_sel;
		logic [23:0] flow_opt;
	} cfg_words_t;
	typedef struct packed {
		logic batch_sel;
		logic reg_en;
		logic manual;
		logic valve;
		logic slow;
		logic fast;
	} status_t;
	typedef enum logic {BATCH_IDLE, BATCH_RUN} batch_st_t;
	// Digit 1 is the leftmost of six BCD digits
	function automatic logic [3:0] digit(input logic [23:0] w,
		input int unsigned n);
		digit = w[(6 - n) * 4 +: 4];
	endfunction
endpackage

// >>> pulse_nco.sv
// Phase accumulator that emits one tick per overflow
`timescale 1ns/1ps
`default_nettype none
module pulse_nco (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	input  wire logic [31:0] inc_i,
	output var  logic        tick_o
);
	logic [31:0] acc_ff;
	logic [32:0] sum;

	assign sum = {1'b0, acc_ff} + {1'b0, inc_i};

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_ff <= 32'h0000_0000;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			acc_ff <= sum[31:0];
			tick_o <= sum[32];
		end
	end
endmodule // pulse_nco
`default_nettype wire

// >>> batch_and_flow_control.sv
// Batch control, pulse outputs and PI flow regulator with APB registers
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module batch_and_flow_control
	import flow_ctrl_pkg::*;
#(
	parameter int SLOW_W = SLOW_WIDTH_CYC,
	parameter int PI_CYC = PI_SAMPLE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output var  logic [31:0] prdata_o,
	output var  logic        pready_o,
	output var  logic        pslverr_o,
	input  wire logic        prog_enable_i,
	input  wire logic        batch_start_input_i,
	input  wire logic        vol_tick_i,
	input  wire logic [15:0] flow_rate_i,
	output var  logic        valve_pump_control_output_o,
	output var  logic        slow_pulse_o,
	output var  logic        fast_pulse_or_current_output_o,
	output var  logic [15:0] current_ua_o,
	output var  logic        regulator_mode_select_o
);
	logic                  rst_meta_ff;
	logic                  rst_sync_b;
	cfg_words_t            cfg_ff;
	logic [15:0]           pband_ff;
	logic [15:0]           itime_ff;
	logic [15:0]           setpoint_ff;
	// Blank cells until first programmed
	logic [15:0]           nv_pband_ff    = VAL_RST;
	logic [15:0]           nv_itime_ff    = VAL_RST;
	logic [15:0]           nv_setpoint_ff = VAL_RST;
	logic                  restore_ff;
	logic                  prog_q_ff;
	logic [15:0]           slow_scale_ff;
	logic [15:0]           fast_scale_ff;
	logic [15:0]           vol_ff;
	batch_st_t             batch_st_ff;
	logic                  start_q_ff;
	logic [SLOW_CNT_W-1:0] slow_cnt_ff;
	logic [PI_CNT_W-1:0]   pi_cnt_ff;
	logic signed [31:0]    integ_ff;
	logic [15:0]           out_ff;
	logic                  batch_sel;
	logic                  reg_en;
	logic                  manual;
	logic                  start_edge;
	logic                  addr_ok;
	logic                  wr_ok;
	logic                  wr_en;
	logic [31:0]           rdata;
	status_t               status;
	logic [31:0]           slow_prod;
	logic [31:0]           fast_prod;
	logic [31:0]           slow_inc;
	logic [31:0]           fast_inc;
	logic                  slow_tick;
	logic                  fast_tick;
	logic                  pi_sample;
	logic [15:0]           pband_eff;
	logic signed [31:0]    err_s;
	logic signed [31:0]    p_s;
	logic signed [31:0]    i_next;
	logic signed [31:0]    sum_s;
	logic [15:0]           out_auto;
	logic [15:0]           pos;
	logic [31:0]           cur_prod;

	// Reset is released through two flops so every flop on rst_sync_b leaves reset together
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_b  <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_b  <= rst_meta_ff;
		end
	end

	// Mode decoding from the configuration words
	assign batch_sel = cfg_ff.reg_cfg == WORD_RST
		&& cfg_ff.func_sel[15:0] == BATCH_FUNC_LO
		&& digit(cfg_ff.flow_opt, 2) == DIGIT_ZERO
		&& digit(cfg_ff.flow_opt, 4) == BATCH_OPT_D4;
	assign reg_en = cfg_ff.reg_cfg[23:8] == VAL_RST
		&& cfg_ff.func_sel[23:16] == PI_FUNC_HI
		&& digit(cfg_ff.func_sel, 5) == DIGIT_ZERO
		&& !batch_sel;
	assign manual = reg_en && digit(cfg_ff.reg_cfg, 6) == MODE_INPUT
		&& batch_start_input_i;
	assign start_edge = batch_start_input_i && !start_q_ff;

	// APB decode; no wait state, answers registered in the setup phase so all come from flops
	always_comb begin
		addr_ok = 1'b1;
		wr_ok   = 1'b1;
		rdata   = 32'h0000_0000;
		case (paddr_i)
			OFS_REG_CFG: begin
				rdata = {8'h00, cfg_ff.reg_cfg};
				wr_ok = prog_enable_i;
			end
			OFS_FUNC_SEL: begin
				rdata = {8'h00, cfg_ff.func_sel};
				wr_ok = prog_enable_i;
			end
			OFS_FLOW_OPT: begin
				rdata = {8'h00, cfg_ff.flow_opt};
				wr_ok = prog_enable_i;
			end
			OFS_PBAND:      rdata = {16'h0000, pband_ff};
			OFS_ITIME:      rdata = {16'h0000, itime_ff};
			OFS_SETPOINT:   rdata = {16'h0000, setpoint_ff};
			OFS_OUT_PCT: begin
				rdata = {16'h0000, out_ff};
				wr_ok = manual;
			end
			OFS_BATCH_VOL: begin
				rdata = {16'h0000, vol_ff};
				wr_ok = 1'b0;
			end
			OFS_STATUS: begin
				rdata = {26'h0000000, status};
				wr_ok = 1'b0;
			end
			OFS_SLOW_SCALE: rdata = {16'h0000, slow_scale_ff};
			OFS_FAST_SCALE: rdata = {16'h0000, fast_scale_ff};
			default: begin
				addr_ok = 1'b0;
				wr_ok   = 1'b0;
			end
		endcase
	end

	assign status = '{batch_sel: batch_sel, reg_en: reg_en, manual: manual,
		valve: valve_pump_control_output_o, slow: slow_pulse_o,
		fast: fast_pulse_or_current_output_o};
	assign wr_en = psel_i && penable_i && pready_o && pwrite_i && wr_ok;

	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			if (psel_i && !penable_i) begin
				pready_o  <= 1'b1;
				prdata_o  <= rdata;
				pslverr_o <= !addr_ok || (pwrite_i && !wr_ok);
			end else begin
				pready_o  <= 1'b0;
				pslverr_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cfg_ff        <= '{WORD_RST, WORD_RST, WORD_RST};
			slow_scale_ff <= VAL_RST;
			fast_scale_ff <= VAL_RST;
		end else if (ce_i && wr_en) begin
			case (paddr_i)
				OFS_REG_CFG:    cfg_ff.reg_cfg  <= pwdata_i[23:0];
				OFS_FUNC_SEL:   cfg_ff.func_sel <= pwdata_i[23:0];
				OFS_FLOW_OPT:   cfg_ff.flow_opt <= pwdata_i[23:0];
				OFS_SLOW_SCALE: slow_scale_ff   <= pwdata_i[15:0];
				OFS_FAST_SCALE: fast_scale_ff   <= pwdata_i[15:0];
				default: ;
			endcase
		end
	end

	// Band, time and setpoint stay writable; first cycle restores stored copy
	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			restore_ff  <= 1'b1;
			pband_ff    <= VAL_RST;
			itime_ff    <= VAL_RST;
			setpoint_ff <= VAL_RST;
		end else if (ce_i) begin
			if (restore_ff) begin
				restore_ff  <= 1'b0;
				pband_ff    <= nv_pband_ff;
				itime_ff    <= nv_itime_ff;
				setpoint_ff <= nv_setpoint_ff;
			end else if (wr_en) begin
				case (paddr_i)
					OFS_PBAND:    pband_ff    <= pwdata_i[15:0];
					OFS_ITIME:    itime_ff    <= pwdata_i[15:0];
					OFS_SETPOINT: setpoint_ff <= pwdata_i[15:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b)
			prog_q_ff <= 1'b0;
		else if (ce_i)
			prog_q_ff <= prog_enable_i;
	end

	// Stored copy survives reset, like a non-volatile cell
	// One more copy as the switch opens keeps a write on its last cycle
	always_ff @(posedge clk_i) begin
		if (ce_i && (prog_enable_i || prog_q_ff) && !restore_ff) begin
			nv_pband_ff    <= pband_ff;
			nv_itime_ff    <= itime_ff;
			nv_setpoint_ff <= setpoint_ff;
		end
	end

	// Batch run; counter keeps counting after close so after-flow shows
	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			start_q_ff                  <= 1'b0;
			batch_st_ff                 <= BATCH_IDLE;
			vol_ff                      <= VAL_RST;
			valve_pump_control_output_o <= 1'b0;
		end else if (ce_i) begin
			start_q_ff <= batch_start_input_i;
			if (batch_sel && start_edge) begin
				batch_st_ff                 <= BATCH_RUN;
				vol_ff                      <= VAL_RST;
				valve_pump_control_output_o <= 1'b1;
			end else begin
				vol_ff <= vol_ff + 16'(vol_tick_i);
				case (batch_st_ff)
					BATCH_RUN: begin
						if (!batch_sel || vol_ff == setpoint_ff) begin
							batch_st_ff                 <= BATCH_IDLE;
							valve_pump_control_output_o <= 1'b0;
						end
					end
					default: begin
						batch_st_ff                 <= BATCH_IDLE;
						valve_pump_control_output_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// Pulse rates follow flow times scale, clamped to each output's range
	assign slow_prod = flow_rate_i * slow_scale_ff;
	assign fast_prod = flow_rate_i * fast_scale_ff;
	assign slow_inc = slow_prod > SLOW_INC_MAX ? SLOW_INC_MAX
		: slow_prod;
	assign fast_inc = fast_prod > FAST_INC_MAX ? FAST_INC_MAX
		: fast_prod;

	pulse_nco u_slow_nco (
		.clk_i   (clk_i),
		.rst_b_i (rst_sync_b),
		.ce_i    (ce_i),
		.inc_i   (slow_inc),
		.tick_o  (slow_tick)
	);

	pulse_nco u_fast_nco (
		.clk_i   (clk_i),
		.rst_b_i (rst_sync_b),
		.ce_i    (ce_i),
		.inc_i   (fast_inc),
		.tick_o  (fast_tick)
	);

	// Ticks during a pulse are dropped; the rate clamp keeps that rare
	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			slow_cnt_ff  <= '0;
			slow_pulse_o <= 1'b0;
		end else if (ce_i) begin
			if (slow_cnt_ff != '0) begin
				slow_cnt_ff <= slow_cnt_ff - 1'b1;
				if (slow_cnt_ff == SLOW_CNT_W'(1))
					slow_pulse_o <= 1'b0;
			end else if (slow_tick) begin
				slow_cnt_ff  <= SLOW_CNT_W'(SLOW_W);
				slow_pulse_o <= 1'b1;
			end
		end
	end

	// Pin is held low while the regulator owns it; the current goes out on current_ua_o
	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b)
			fast_pulse_or_current_output_o <= 1'b0;
		else if (ce_i) begin
			if (reg_en)
				fast_pulse_or_current_output_o <= 1'b0;
			else if (fast_tick)
				fast_pulse_or_current_output_o <=
					!fast_pulse_or_current_output_o;
		end
	end

	// PI regulator
	assign pi_sample = pi_cnt_ff == PI_CNT_W'(PI_CYC - 1);
	assign pband_eff = pband_ff == VAL_RST ? 16'h0001 : pband_ff;
	assign err_s = $signed({16'h0000, setpoint_ff})
		- $signed({16'h0000, flow_rate_i});
	assign p_s = (err_s * $signed({16'h0000, OUT_FULL}))
		/ $signed({16'h0000, pband_eff});
	assign i_next = itime_ff == VAL_RST ? integ_ff : integ_ff + p_s
		/ $signed(32'(itime_ff) * 32'(SAMPLES_PER_S));
	assign sum_s = p_s + i_next;
	assign out_auto = sum_s < 0 ? VAL_RST
		: sum_s > $signed({16'h0000, OUT_FULL}) ? OUT_FULL : sum_s[15:0];

	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b)
			pi_cnt_ff <= '0;
		else if (ce_i)
			pi_cnt_ff <= pi_sample ? '0 : pi_cnt_ff + 1'b1;
	end

	// Integral tracks the manual position so the return to auto is smooth
	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			integ_ff <= '0;
			out_ff   <= VAL_RST;
		end else if (ce_i) begin
			if (!reg_en) begin
				integ_ff <= '0;
				out_ff   <= VAL_RST;
			end else if (manual) begin
				integ_ff <= $signed({16'h0000, out_ff}) - p_s;
				if (wr_en && paddr_i == OFS_OUT_PCT)
					out_ff <= pwdata_i[15:0] > OUT_FULL ? OUT_FULL
						: pwdata_i[15:0];
			end else if (pi_sample) begin
				integ_ff <= i_next > $signed({16'h0000, OUT_FULL})
					? $signed({16'h0000, OUT_FULL}) : i_next;
				out_ff   <= out_auto;
			end
		end
	end

	assign pos = digit(cfg_ff.reg_cfg, 5) == SENSE_OPEN ? OUT_FULL - out_ff
		: out_ff;
	assign cur_prod = pos * CUR_SPAN_UA;

	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			current_ua_o            <= CUR_MIN_UA;
			regulator_mode_select_o <= 1'b0;
		end else if (ce_i) begin
			current_ua_o <= CUR_MIN_UA
				+ 16'(cur_prod / 32'(OUT_FULL));
			regulator_mode_select_o <= manual;
		end
	end

	// Checks
	logic [SLOW_CNT_W:0] hi_len_ff;
	always_ff @(posedge clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b)
			hi_len_ff <= '0;
		else if (ce_i)
			hi_len_ff <= slow_pulse_o ? hi_len_ff + 1'b1 : '0;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_sync_b);

	property p_slow_width;
		ce_i && slow_pulse_o && hi_len_ff == (SLOW_CNT_W + 1)'(SLOW_W - 1)
			|=> !slow_pulse_o || !$past(ce_i);
	endproperty
	a_slow_width: assert property (p_slow_width)
		else $error("slow pulse width wrong");
	property p_fast_toggle;
		ce_i && fast_tick && !reg_en |=> fast_pulse_or_current_output_o
			!= $past(fast_pulse_or_current_output_o);
	endproperty
	a_fast_toggle: assert property (p_fast_toggle)
		else $error("fast output missed a toggle");
	property p_batch_start;
		ce_i && batch_sel && start_edge
			|=> valve_pump_control_output_o && vol_ff == VAL_RST;
	endproperty
	a_batch_start: assert property (p_batch_start)
		else $error("batch start did not open valve");
	property p_batch_stop;
		ce_i && !start_edge && valve_pump_control_output_o
			&& vol_ff == setpoint_ff |=> !valve_pump_control_output_o;
	endproperty
	a_batch_stop: assert property (p_batch_stop)
		else $error("valve stayed on at setpoint");
	property p_exclusive;
		batch_sel |-> !reg_en && out_ff == VAL_RST ##1 1'b1;
	endproperty
	a_exclusive: assert property (p_exclusive)
		else $error("regulator active in batch mode");
	property p_cfg_lock;
		ce_i && !prog_enable_i |=> $stable(cfg_ff);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock)
		else $error("config changed without program enable");
	property p_restore;
		$fell(restore_ff) |-> setpoint_ff == $past(nv_setpoint_ff);
	endproperty
	a_restore: assert property (p_restore)
		else $error("setpoint not restored");
	property p_current_range;
		current_ua_o >= CUR_MIN_UA && current_ua_o <= CUR_MIN_UA + CUR_SPAN_UA;
	endproperty
	a_current_range: assert property (p_current_range)
		else $error("current outside 4-20 mA");
	property p_manual_write;
		ce_i && reg_en && manual && wr_en && paddr_i == OFS_OUT_PCT
			&& pwdata_i[15:0] <= OUT_FULL |=> out_ff == $past(pwdata_i[15:0]);
	endproperty
	a_manual_write: assert property (p_manual_write)
		else $error("manual position not applied");
	property p_auto_only;
		reg_en && digit(cfg_ff.reg_cfg, 6) == DIGIT_ZERO |-> !manual;
	endproperty
	a_auto_only: assert property (p_auto_only)
		else $error("manual mode with B zero");
	property p_nv_copy;
		ce_i && prog_enable_i && !restore_ff
			|=> nv_setpoint_ff == $past(setpoint_ff);
	endproperty
	a_nv_copy: assert property (p_nv_copy)
		else $error("stored setpoint not updated");
	c_batch_done: cover property ($fell(valve_pump_control_output_o));
	c_slow_pulse: cover property ($rose(slow_pulse_o));
	c_manual: cover property (manual && wr_en);
endmodule // batch_and_flow_control
`default_nettype wire

// >>> flow_valve_model.sv
// Valve or pump model with a fixed after-flow, giving volume ticks
`timescale 1ns/1ps
`default_nettype none
module flow_valve_model #(
	parameter int TICK_GAP    = 4,
	parameter int AFTER_TICKS = 3
) (
	input  wire logic clk_i,
	input  wire logic valve_i,
	output var  logic vol_tick_o
);
	int   left_ff = 0;
	int   gap_ff  = 0;
	logic tick_ff = 1'b0;
	assign vol_tick_o = tick_ff;
	// Valve reacts late, so product keeps flowing after close
	always @(posedge clk_i) begin
		tick_ff <= 1'b0;
		if (valve_i)
			left_ff <= AFTER_TICKS;
		if (valve_i || left_ff != 0) begin
			gap_ff <= (gap_ff == TICK_GAP - 1) ? 0 : gap_ff + 1;
			if (gap_ff == TICK_GAP - 1) begin
				tick_ff <= 1'b1;
				if (!valve_i)
					left_ff <= left_ff - 1;
			end
		end else
			gap_ff <= 0;
	end
endmodule // flow_valve_model
`default_nettype wire

// >>> batch_and_flow_control_tb.sv
// Self-checking testbench for the batch and flow control block
`timescale 1ns/1ps
`default_nettype none
module batch_and_flow_control_tb;
	import flow_ctrl_pkg::*;
	localparam int AFTER = 3;
	logic        clk       = 1'b0;
	logic        rst_b     = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        prog_en   = 1'b0;
	logic        start     = 1'b0;
	logic        vol_tick;
	logic [15:0] flow_rate = 16'h0;
	logic        valve;
	logic        slow;
	logic        fast;
	logic [15:0] current;
	logic        manual;
	int          error_cnt = 0;
	int          tests_run = 0;

	initial forever #25 clk = ~clk;

	batch_and_flow_control #(.SLOW_W(20), .PI_CYC(50)) dut_u (
		.clk_i                         (clk),
		.rst_b_i                       (rst_b),
		.ce_i                          (1'b1),
		.psel_i                        (psel),
		.penable_i                     (penable),
		.pwrite_i                      (pwrite),
		.paddr_i                       (paddr),
		.pwdata_i                      (pwdata),
		.prdata_o                      (prdata),
		.pready_o                      (pready),
		.pslverr_o                     (pslverr),
		.prog_enable_i                 (prog_en),
		.batch_start_input_i           (start),
		.vol_tick_i                    (vol_tick),
		.flow_rate_i                   (flow_rate),
		.valve_pump_control_output_o   (valve),
		.slow_pulse_o                  (slow),
		.fast_pulse_or_current_output_o(fast),
		.current_ua_o                  (current),
		.regulator_mode_select_o       (manual)
	);

	flow_valve_model #(.TICK_GAP(4), .AFTER_TICKS(AFTER)) valve_u (
		.clk_i     (clk),
		.valve_i   (valve),
		.vol_tick_o(vol_tick)
	);

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Master waits on pready; only the bench timeout ends a hang
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] r;
		logic        x;
		apb(1'b1, a, d, r, x);
		chk($sformatf("error flag at %h", a), 32'(x), 32'(e));
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        x;
		apb(1'b0, a, 32'h0, r, x);
		chk($sformatf("read of %h", a), r, exp);
	endtask

	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	function automatic logic [31:0] cur_of(input int pos);
		return 32'(CUR_MIN_UA) + 32'(pos) * 32'(CUR_SPAN_UA) / 32'(OUT_FULL);
	endfunction

	task automatic t_regs;
		chk("current at reset", 32'(current), cur_of(0));
		rdc(OFS_STATUS, 32'h0);
		wr(OFS_REG_CFG, 32'h123456, 1'b1);
		rdc(OFS_REG_CFG, 32'h0);
		wr(8'h3c, 32'h0, 1'b1);
		wr(OFS_BATCH_VOL, 32'h5, 1'b1);
		$display("test regs done");
	endtask

	task automatic t_batch;
		int sp;
		int k;
		int n;
		prog_en <= 1'b1;
		wr(OFS_REG_CFG, 32'h000000, 1'b0);
		wr(OFS_FUNC_SEL, 32'h002106, 1'b0);
		wr(OFS_FLOW_OPT, 32'h000400, 1'b0);
		wr(OFS_SETPOINT, 32'h6, 1'b0);
		prog_en <= 1'b0;
		rdc(OFS_STATUS, 32'h20);
		for (int run = 0; run < 2; run++) begin
			sp = (run == 0) ? 6 : 6 - AFTER;
			k = 0;
			n = 0;
			// Second run trims setpoint by the model's fixed after-flow AFTER
			if (run == 1)
				wr(OFS_SETPOINT, 32'(sp), 1'b0);
			@(posedge clk);
			start <= 1'b1;
			@(posedge clk);
			#1 chk("valve on at start", 32'(valve), 32'h1);
			while (valve === 1'b1 && n < 400) begin
				@(posedge clk);
				if (vol_tick === 1'b1 && valve === 1'b1)
					k++;
				n++;
			end
			chk("ticks while open", 32'(k), 32'(sp));
			repeat (40) @(posedge clk);
			start <= 1'b0;
			rdc(OFS_BATCH_VOL, 32'(sp + AFTER));
		end
		do_reset();
		rdc(OFS_SETPOINT, 32'h6);
		$display("test batch done");
	endtask

	task automatic t_reg;
		prog_en <= 1'b1;
		wr(OFS_REG_CFG, 32'h000002, 1'b0);
		wr(OFS_FUNC_SEL, 32'h180000, 1'b0);
		wr(OFS_PBAND, 32'h64, 1'b0);
		wr(OFS_ITIME, 32'h0, 1'b0);
		prog_en <= 1'b0;
		rdc(OFS_STATUS, 32'h10);
		wr(OFS_OUT_PCT, 32'h1388, 1'b1);
		start <= 1'b1;
		repeat (3) @(posedge clk);
		chk("manual select", 32'(manual), 32'h1);
		for (int p = 0; p <= 10000; p += 5000) begin
			wr(OFS_OUT_PCT, 32'(p), 1'b0);
			repeat (3) @(posedge clk);
			chk("loop current", 32'(current), cur_of(p));
			rdc(OFS_OUT_PCT, 32'(p));
		end
		chk("fast pin held", 32'(fast), 32'h0);
		prog_en <= 1'b1;
		wr(OFS_REG_CFG, 32'h000022, 1'b0);
		prog_en <= 1'b0;
		wr(OFS_OUT_PCT, 32'h9c4, 1'b0);
		repeat (3) @(posedge clk);
		chk("open-sense current", 32'(current), cur_of(7500));
		prog_en <= 1'b1;
		wr(OFS_REG_CFG, 32'h000020, 1'b0);
		prog_en <= 1'b0;
		repeat (3) @(posedge clk);
		chk("always auto", 32'(manual), 32'h0);
		// Band 100 units: a 16 unit rise pulls output down by 16 %
		flow_rate <= 16'd16;
		repeat (60) @(posedge clk);
		rdc(OFS_OUT_PCT, 32'd900);
		chk("auto current", 32'(current), cur_of(10000 - 900));
		start <= 1'b0;
		$display("test regulator done");
	endtask

	task automatic wait_tog(output int c);
		logic p = fast;
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (fast === p && c < 25000);
	endtask

	task automatic t_fast;
		int h1;
		int h2;
		int ex;
		// Long half periods: this scenario costs most of the run time
		ex = int'((64'h1 << 32) / 64'(FAST_INC_MAX));
		do_reset();
		wr(OFS_FAST_SCALE, 32'h0000ffff, 1'b0);
		flow_rate <= 16'hffff;
		wait_tog(h1);
		wait_tog(h1);
		wait_tog(h2);
		chk("fast half", 32'(h1 >= ex && h1 <= ex + 1), 32'h1);
		chk("fast symmetry", 32'(h2 - h1 <= 1 && h1 - h2 <= 1), 32'h1);
		flow_rate <= 16'h0;
		wait_tog(h1);
		chk("fast idle at no flow", 32'(h1), 32'd25000);
		chk("slow idle", 32'(slow), 32'h0);
		$display("test fast pulse done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		$display("timeout");
		tally_and_finish();
	end

	initial begin
		do_reset();
		t_regs();
		t_batch();
		t_reg();
		t_fast();
		tally_and_finish();
	end
endmodule // batch_and_flow_control_tb
`default_nettype wire
